// file: logic/cmd_shaping_pkg.sv
// constants shared by the command-shaping block and its two helper modules
// assumes a single 50 MHz clock domain and a word-only AHB-Lite master
package cmd_shaping_pkg;

  // clock and switch hold time
  localparam int CLK_HZ = 50_000_000;
  localparam int FLIP_HOLD_MS = 500;
  localparam int FLIP_HOLD_CYCLES = CLK_HZ / 1000 * FLIP_HOLD_MS;
  localparam int HOLD_CNT_W = 25;

  // register byte offsets
  localparam logic [31:0] CONFIG_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;

  // config field positions
  localparam int CURVE1_LSB = 0;
  localparam int CURVE2_LSB = 4;
  localparam int BALANCE_LSB = 8;
  localparam int STOP_MODE_LSB = 12;
  localparam int IN_E_MODE_LSB = 16;
  localparam int IN_F_MODE_LSB = 18;
  localparam int ACTIVITY_BIT = 20;
  localparam int MIXED_BIT = 21;
  localparam int CLOSED1_BIT = 22;
  localparam int CLOSED2_BIT = 23;

  // config reset value and implemented bits
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0700;
  localparam logic [31:0] CONFIG_WMASK = 32'h00FF_3F77;

  // status field positions
  localparam int ST_ESTOP_BIT = 0;
  localparam int ST_INVERT_BIT = 1;
  localparam int ST_DRIVE_BIT = 2;
  localparam int ST_ACC_BIT = 3;
  localparam int ST_CMD1_LSB = 8;
  localparam int ST_CMD2_LSB = 16;

  // response curve encodings
  localparam logic [2:0] CURVE_LINEAR = 3'h0;
  localparam logic [2:0] CURVE_STRONG_EXP = 3'h1;
  localparam logic [2:0] CURVE_EXP = 3'h2;
  localparam logic [2:0] CURVE_LOG = 3'h3;
  localparam logic [2:0] CURVE_STRONG_LOG = 3'h4;

  // balance: neutral step, top step, step size and unity in q12
  localparam logic [3:0] BALANCE_NEUTRAL = 4'h7;
  localparam logic [3:0] BALANCE_MAX = 4'hE;
  localparam logic [12:0] BAL_STEP_Q12 = 13'h001F;
  localparam logic [12:0] UNITY_Q12 = 13'h1000;
  localparam logic [6:0] FULL_SCALE = 7'h7F;

  // switch input modes
  localparam logic [1:0] STOP_NONE = 2'h0;
  localparam logic [1:0] STOP_ESTOP = 2'h1;
  localparam logic [1:0] STOP_INVERT = 2'h2;
  localparam logic [1:0] IN_IGNORE = 2'h0;
  localparam logic [1:0] IN_DRIVE_OUT = 2'h1;
  localparam logic [1:0] IN_DEADMAN = 2'h2;

  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// file: logic/level_filter.sv
// two-flop synchroniser followed by a hold-time filter for one pin
// assumes the pin is asynchronous to hclk; output flips after HOLD_CYCLES
`timescale 1ns/100ps
module level_filter
  import cmd_shaping_pkg::*;
#(
  parameter int HOLD_CYCLES = 1,
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_in,
  output logic level_out
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic stable;
    logic [HOLD_CNT_W-1:0] cnt;
  } filt_t;

  filt_t f_reg;
  filt_t f_next;

  // synchroniser then filter; sync1 feeds only sync2
  always_comb begin
    f_next = f_reg;
    f_next.sync1 = pin_in;
    f_next.sync2 = f_reg.sync1;
    if (f_reg.sync2 == f_reg.stable) begin
      f_next.cnt = '0;
    end else if (f_reg.cnt == HOLD_CNT_W'(HOLD_CYCLES - 1)) begin
      f_next.stable = f_reg.sync2;
      f_next.cnt = '0;
    end else begin
      f_next.cnt = f_reg.cnt + HOLD_CNT_W'(1);
    end
  end

  // short excursions reset the count, so bounces never reach the output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      f_reg <= '{sync1: RESET_LEVEL, sync2: RESET_LEVEL, stable: RESET_LEVEL, cnt: '0};
    end else begin
      f_reg <= f_next;
    end
  end

  assign level_out = f_reg.stable;

endmodule

// file: logic/curve_shaper.sv
// combinational response curve and direction balance for one channel
// assumes a signed 8-bit command; result is registered by the caller
`timescale 1ns/100ps
module curve_shaper
  import cmd_shaping_pkg::*;
(
  input wire logic [7:0] cmd_in,
  input wire logic [2:0] curve_sel,
  input wire logic [3:0] balance,
  input wire logic balance_en,
  output logic [7:0] cmd_out
);

  // a*(b+1)/128: maps full scale to full scale without a divider
  function automatic logic [6:0] mul_q7(input logic [6:0] a, input logic [6:0] b);
    logic [14:0] p;
    p = 15'(a) * (15'(b) + 15'h0001);
    return p[13:7];
  endfunction

  logic neg;
  logic [7:0] mag_full;
  logic [6:0] mag;
  logic [6:0] rest;
  logic [6:0] sq;
  logic [6:0] rsq;
  logic [7:0] log_sum;
  logic [6:0] shaped;
  logic [3:0] bal;
  logic [3:0] steps;
  logic reduce;
  logic [12:0] factor;
  logic [19:0] p_bal;
  logic [6:0] mag_bal;

  // magnitude, curve, balance, sign back on
  always_comb begin
    neg = cmd_in[7];
    mag_full = neg ? (8'h00 - cmd_in) : cmd_in;
    mag = mag_full[7] ? FULL_SCALE : mag_full[6:0];
    rest = FULL_SCALE - mag;
    sq = mul_q7(mag, mag);
    rsq = mul_q7(rest, rest);
    log_sum = {mag, 1'b0} - {1'b0, sq};
    case (curve_sel)
      CURVE_STRONG_EXP: shaped = mul_q7(sq, mag);
      CURVE_EXP: shaped = sq;
      CURVE_LOG: shaped = log_sum[6:0];
      CURVE_STRONG_LOG: shaped = FULL_SCALE - mul_q7(rsq, rest);
      default: shaped = mag;
    endcase
    bal = (balance > BALANCE_MAX) ? BALANCE_MAX : balance;
    if (bal >= BALANCE_NEUTRAL) begin
      steps = bal - BALANCE_NEUTRAL;
      reduce = neg;
    end else begin
      steps = BALANCE_NEUTRAL - bal;
      reduce = !neg;
    end
    factor = UNITY_Q12 - 13'(steps) * BAL_STEP_Q12;
    p_bal = 20'(shaped) * 20'(factor);
    if (balance_en && reduce) begin
      mag_bal = p_bal[18:12];
    end else begin
      mag_bal = shaped;
    end
    cmd_out = neg ? (8'h00 - {1'b0, mag_bal}) : {1'b0, mag_bal};
  end

endmodule

// file: logic/motor_command_shaping.sv
// command shaping and safety-input logic for a two-channel motor stage
// assumes an AHB-Lite master on hclk, switch pins asynchronous to hclk,
// and commands from logic on hclk with a one-cycle update strobe
//
// How it works
// - separate curve selection per channel
// - curve codes zero to four, linear default
// - linear curve is proportional
// - exponential rises slowly then steeply
// - logarithmic rises steeply then flattens
// - open loop balance by scale factor
// - balance zero to fourteen, seven neutral
// - balance reduces, never boosts
// - balance after curve, off in closed loop
// - accessory follows motor activity when enabled
// - switch mode none, stop or flip
// - stop latches until reset
// - inversion only in mixed flip mode
// - closed flip switch reverses commands
// - flip change needs half second stable
// - inputs e and f ignored by default
// - grounded input turns accessory on
// - high dead-man input frees the motors
`timescale 1ns/100ps
module motor_command_shaping
  import cmd_shaping_pkg::*;
#(
  parameter int FLIP_HOLD = FLIP_HOLD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] cmd_ch1,
  input wire logic [7:0] cmd_ch2,
  input wire logic cmd_valid,
  input wire logic stop_or_flip_input,
  input wire logic input_e_n,
  input wire logic input_f_n,
  output logic [7:0] motor_cmd_ch1,
  output logic [7:0] motor_cmd_ch2,
  output logic motor_cmd_valid,
  output logic power_stage_en,
  output logic emergency_stopped,
  output logic accessory_out
);

  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] rdata;
    logic ready;
    logic wr_cfg_pend;
    logic [7:0] shaped1;
    logic [7:0] shaped2;
    logic upd_pend;
    logic estop_latched;
    logic inverted;
    logic [7:0] out1;
    logic [7:0] out2;
    logic out_valid;
    logic drive_en;
    logic accessory;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic flip_level;
  logic e_level;
  logic f_level;
  logic [7:0] shaped_ch1;
  logic [7:0] shaped_ch2;

  // config fields, decoded from the current register value
  logic [2:0] curve1;
  logic [2:0] curve2;
  logic [3:0] balance;
  logic [1:0] stop_mode;
  logic [1:0] e_mode;
  logic [1:0] f_mode;
  logic activity_en;
  logic mixed_mode;
  logic closed1;
  logic closed2;

  assign curve1 = s_reg.cfg[CURVE1_LSB +: 3];
  assign curve2 = s_reg.cfg[CURVE2_LSB +: 3];
  assign balance = s_reg.cfg[BALANCE_LSB +: 4];
  assign stop_mode = s_reg.cfg[STOP_MODE_LSB +: 2];
  assign e_mode = s_reg.cfg[IN_E_MODE_LSB +: 2];
  assign f_mode = s_reg.cfg[IN_F_MODE_LSB +: 2];
  assign activity_en = s_reg.cfg[ACTIVITY_BIT];
  assign mixed_mode = s_reg.cfg[MIXED_BIT];
  assign closed1 = s_reg.cfg[CLOSED1_BIT];
  assign closed2 = s_reg.cfg[CLOSED2_BIT];

  // flip switch waits out bounces; the stop reading shares this filter,
  // so a closed stop switch takes effect only after the same hold time
  level_filter #(
    .HOLD_CYCLES(FLIP_HOLD),
    .RESET_LEVEL(1'b0)
  ) u_flip_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(stop_or_flip_input),
    .level_out(flip_level)
  );

  // accessory inputs are only synchronised, no hold time
  level_filter #(
    .HOLD_CYCLES(1),
    .RESET_LEVEL(1'b1)
  ) u_e_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(input_e_n),
    .level_out(e_level)
  );

  level_filter #(
    .HOLD_CYCLES(1),
    .RESET_LEVEL(1'b1)
  ) u_f_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(input_f_n),
    .level_out(f_level)
  );

  curve_shaper u_shape_ch1 (
    .cmd_in(cmd_ch1),
    .curve_sel(curve1),
    .balance(balance),
    .balance_en(!closed1),
    .cmd_out(shaped_ch1)
  );

  curve_shaper u_shape_ch2 (
    .cmd_in(cmd_ch2),
    .curve_sel(curve2),
    .balance(balance),
    .balance_en(!closed2),
    .cmd_out(shaped_ch2)
  );

  // next-state logic: bus slave, command capture, safety gating
  always_comb begin
    logic take;
    logic deadman_off;
    logic invert_now;
    logic driven;
    logic acc_inputs;
    logic [31:0] status_word;
    take = 1'b0;
    deadman_off = 1'b0;
    invert_now = 1'b0;
    driven = 1'b0;
    acc_inputs = 1'b0;
    status_word = '0;
    s_next = s_reg;

    // zero-wait slave: always ready, always okay
    s_next.ready = 1'b1;
    take = hsel && hready && htrans[1];

    // write data phase: config only, status is read-only
    if (s_reg.wr_cfg_pend) begin
      s_next.cfg = hwdata & CONFIG_WMASK;
    end
    s_next.wr_cfg_pend = take && hwrite && (hsize == HSIZE_WORD)
                         && (haddr == CONFIG_OFFSET);

    // status snapshot of the block's own state
    status_word[ST_ESTOP_BIT] = s_reg.estop_latched;
    status_word[ST_INVERT_BIT] = s_reg.inverted;
    status_word[ST_DRIVE_BIT] = s_reg.drive_en;
    status_word[ST_ACC_BIT] = s_reg.accessory;
    status_word[ST_CMD1_LSB +: 8] = s_reg.out1;
    status_word[ST_CMD2_LSB +: 8] = s_reg.out2;

    // read data registered in the address phase; config reads the value
    // about to be written so a read right after a write is not stale
    if (take && !hwrite) begin
      if (haddr == CONFIG_OFFSET) begin
        s_next.rdata = s_next.cfg;
      end else if (haddr == STATUS_OFFSET) begin
        s_next.rdata = status_word;
      end else begin
        s_next.rdata = '0;
      end
    end

    // shape with config of this update
    s_next.upd_pend = cmd_valid;
    if (cmd_valid) begin
      s_next.shaped1 = shaped_ch1;
      s_next.shaped2 = shaped_ch2;
    end

    if (stop_mode == STOP_ESTOP && flip_level) begin
      s_next.estop_latched = 1'b1;
    end

    invert_now = mixed_mode && (stop_mode == STOP_INVERT) && flip_level;
    s_next.inverted = invert_now;

    deadman_off = ((e_mode == IN_DEADMAN) && e_level)
                  || ((f_mode == IN_DEADMAN) && f_level);
    s_next.drive_en = !deadman_off;

    // commands: stop forces zero, inversion negates both channels
    if (s_next.estop_latched) begin
      s_next.out1 = 8'h00;
      s_next.out2 = 8'h00;
    end else if (invert_now) begin
      s_next.out1 = 8'h00 - s_reg.shaped1;
      s_next.out2 = 8'h00 - s_reg.shaped2;
    end else begin
      s_next.out1 = s_reg.shaped1;
      s_next.out2 = s_reg.shaped2;
    end
    s_next.out_valid = s_reg.upd_pend;

    acc_inputs = ((e_mode == IN_DRIVE_OUT) && !e_level)
                 || ((f_mode == IN_DRIVE_OUT) && !f_level);

    driven = s_next.drive_en && ((s_next.out1 != 8'h00) || (s_next.out2 != 8'h00));
    s_next.accessory = acc_inputs || (activity_en && driven);
  end

  // single state register; only constants under reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{cfg: CONFIG_RESET, rdata: '0, ready: 1'b1, wr_cfg_pend: 1'b0,
                 shaped1: '0, shaped2: '0, upd_pend: 1'b0, estop_latched: 1'b0,
                 inverted: 1'b0, out1: '0, out2: '0, out_valid: 1'b0,
                 drive_en: 1'b0, accessory: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register, except hresp tied to zero
  assign hreadyout = s_reg.ready;
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign motor_cmd_ch1 = s_reg.out1;
  assign motor_cmd_ch2 = s_reg.out2;
  assign motor_cmd_valid = s_reg.out_valid;
  assign power_stage_en = s_reg.drive_en;
  assign emergency_stopped = s_reg.estop_latched;
  assign accessory_out = s_reg.accessory;

endmodule

// file: verification/operator_side.sv
// operator model: joystick commands and the three switch pins
// driven just after hclk edges; the bench calls its tasks
`timescale 1ns/100ps
module operator_side (
  input wire logic hclk,
  output logic [7:0] cmd_ch1,
  output logic [7:0] cmd_ch2,
  output logic cmd_valid,
  output logic stop_or_flip_input,
  output logic input_e_n,
  output logic input_f_n
);
  initial begin
    {cmd_ch1, cmd_ch2, cmd_valid, stop_or_flip_input} = 18'h0;
    {input_e_n, input_f_n} = 2'h3;
  end
  // one-cycle strobe; data inverted after so stale values never pass
  task automatic send(input logic [7:0] a, input logic [7:0] b);
    @(posedge hclk);
    cmd_ch1 <= a;
    cmd_ch2 <= b;
    cmd_valid <= 1'b1;
    @(posedge hclk);
    cmd_valid <= 1'b0;
    {cmd_ch1, cmd_ch2} <= ~{a, b};
  endtask
  // flip switch reads 1 when closed
  task automatic pins(input logic s, input logic e, input logic f);
    @(posedge hclk);
    stop_or_flip_input <= s;
    input_e_n <= e;
    input_f_n <= f;
  endtask
endmodule

// file: verification/motor_command_shaping_assertions.sv
// port assertions for the command-shaping block
// bound into every motor_command_shaping instance
`timescale 1ns/100ps
module motor_command_shaping_assertions #(
  parameter int FLIP_HOLD = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] cmd_ch1,
  input wire logic cmd_valid,
  input wire logic stop_or_flip_input,
  input wire logic input_e_n,
  input wire logic input_f_n,
  input wire logic [7:0] motor_cmd_ch1,
  input wire logic [7:0] motor_cmd_ch2,
  input wire logic motor_cmd_valid,
  input wire logic power_stage_en,
  input wire logic emergency_stopped,
  input wire logic accessory_out
);
  int hi_reg;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // closed-pin run length; the filter may not act sooner
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_reg <= 0;
    end else begin
      hi_reg <= stop_or_flip_input ? hi_reg + 1 : 0;
    end
  end
  AST_CMD_LAT: assert property (cmd_valid |-> ##2 motor_cmd_valid)
    else $error("late result");
  AST_CMD_SRC: assert property (motor_cmd_valid |-> $past(cmd_valid, 2))
    else $error("result without command");
  AST_ZERO: assert property (cmd_valid && cmd_ch1 == 8'h00 |-> ##2 !motor_cmd_ch1)
    else $error("zero command moved");
  AST_STOP_KEEP: assert property (emergency_stopped |=> emergency_stopped)
    else $error("stop flag cleared");
  AST_STOP_ZERO: assert property (emergency_stopped |-> ##2 !(motor_cmd_ch1 | motor_cmd_ch2))
    else $error("running while stopped");
  AST_STOP_HOLD: assert property ($rose(emergency_stopped) |-> hi_reg >= FLIP_HOLD)
    else $error("stop before hold time");
  AST_DEADMAN: assert property ($fell(power_stage_en) |-> input_e_n || input_f_n)
    else $error("power off with inputs grounded");
  AST_ACC: assert property ($rose(accessory_out) |->
    !input_e_n || !input_f_n || (motor_cmd_ch1 | motor_cmd_ch2) != 8'h00)
    else $error("accessory on without cause");
  cover property ($rose(emergency_stopped));
  cover property ($fell(power_stage_en));
  cover property ($rose(accessory_out));
endmodule
bind motor_command_shaping motor_command_shaping_assertions #(.FLIP_HOLD(FLIP_HOLD)) chk_u (
  .hclk, .hresetn, .cmd_ch1, .cmd_valid, .stop_or_flip_input, .input_e_n, .input_f_n,
  .motor_cmd_ch1, .motor_cmd_ch2, .motor_cmd_valid, .power_stage_en, .emergency_stopped,
  .accessory_out
);

// file: verification/motor_command_shaping_tb.sv
// bench: random and corner commands, then switch and input cases
// operator_side drives commands and pins; bus tasks act as AHB-Lite master
`timescale 1ns/100ps
module motor_command_shaping_tb;
  import cmd_shaping_pkg::*;
  localparam int FH = 16;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, cmd_valid, motor_cmd_valid;
  logic stop_or_flip_input, input_e_n, input_f_n, power_stage_en, emergency_stopped;
  logic accessory_out;
  logic [1:0] htrans, cl;
  logic [2:0] hsize, k1, k2;
  logic [3:0] bal;
  logic [7:0] cmd_ch1, cmd_ch2, motor_cmd_ch1, motor_cmd_ch2, a, b;
  logic [31:0] haddr, hwdata, hrdata, rd, cfg;
  int err_total, n_checks;
  wire logic hready = hreadyout;
  motor_command_shaping #(.FLIP_HOLD(FH)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .cmd_ch1, .cmd_ch2, .cmd_valid, .stop_or_flip_input,
    .input_e_n, .input_f_n, .motor_cmd_ch1, .motor_cmd_ch2, .motor_cmd_valid,
    .power_stage_en, .emergency_stopped, .accessory_out
  );
  operator_side part (
    .hclk, .cmd_ch1, .cmd_ch2, .cmd_valid, .stop_or_flip_input, .input_e_n, .input_f_n
  );
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic wn(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // one single-word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic [7:0] q(input logic [7:0] x, input logic [7:0] y);
    return 8'((16'(x) * (16'(y) + 16'h1)) >> 7);
  endfunction
  // expected curve, then balance unless closed loop
  function automatic logic [7:0] shape(input logic [7:0] c, input logic [2:0] k,
      input logic [3:0] bl, input logic cl1);
    logic [7:0] m, r;
    logic [31:0] f;
    m = c[7] ? ((c == 8'h80) ? 8'h7F : 8'(-c)) : c;
    r = 8'h7F - m;
    f = 32'h1000 - 32'(bl > 7 ? bl - 7 : 7 - bl) * 32'h1F;
    case (k)
      3'h1: m = q(q(m, m), m);
      3'h2: m = q(m, m);
      3'h3: m = (m << 1) - q(m, m);
      3'h4: m = 8'h7F - q(q(r, r), r);
      default: m = m;
    endcase
    // only the slowed direction shrinks; full scale is never exceeded
    if (!cl1 && (bl > 7) == c[7]) m = 8'((32'(m) * f) >> 12);
    return c[7] ? 8'(-m) : m;
  endfunction
  task automatic cmd(input logic [7:0] x, y, ex, ey);
    part.send(x, y);
    wn(1);
    chk(motor_cmd_valid, 1'b1);
    chk(motor_cmd_ch1, ex);
    chk(motor_cmd_ch2, ey);
  endtask
  task automatic final_report();
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard, far past the expected run
  initial begin
    repeat (8000) @(posedge hclk);
    err_total++;
    final_report();
  end
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = 71'h0;
    hresetn = 1'b0;
    err_total = 0;
    n_checks = 0;
    void'($urandom(32'h848934AA));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, CONFIG_OFFSET, 32'h0);
    chk(rd, 32'h0000_0700);
    bus(1'b0, 32'h0000_0010, 32'h0);
    chk(rd, 32'h0);
    part.pins(1'b0, 1'b0, 1'b0);
    wn(8);
    chk(power_stage_en, 1'b1);
    chk(accessory_out, 1'b0);
    // corners first: every curve, balance extremes, full-scale commands
    for (int i = 0; i < 40; i++) begin
      k1 = (i < 5) ? 3'(i) : 3'($urandom_range(4));
      k2 = 3'($urandom_range(4));
      bal = (i < 5) ? ((i % 2) ? 4'hE : 4'h0) : 4'($urandom_range(14));
      cl = (i < 5) ? 2'h0 : 2'($urandom);
      a = (i < 5) ? ((i % 2) ? 8'h80 : 8'h7F) : 8'($urandom);
      b = (i < 5) ? 8'h81 : 8'($urandom);
      cfg = {8'h00, cl, 10'h000, bal, 1'b0, k2, 1'b0, k1};
      bus(1'b1, CONFIG_OFFSET, cfg);
      bus(1'b0, CONFIG_OFFSET, 32'h0);
      chk(rd, cfg);
      cmd(a, b, shape(a, k1, bal, cl[0]), shape(b, k2, bal, cl[1]));
    end
    // flip switch in mixed mode: short bounce, then held
    bus(1'b1, CONFIG_OFFSET, 32'h0020_2700);
    part.pins(1'b1, 1'b0, 1'b0);
    wn(FH / 2);
    part.pins(1'b0, 1'b0, 1'b0);
    wn(FH + 8);
    cmd(8'h20, 8'hE0, 8'h20, 8'hE0);
    part.pins(1'b1, 1'b0, 1'b0);
    wn(FH + 8);
    cmd(8'h20, 8'hE0, 8'hE0, 8'h20);
    bus(1'b1, CONFIG_OFFSET, 32'h0000_2700);
    cmd(8'h20, 8'hE0, 8'h20, 8'hE0);
    // input E as dead-man, input F drives the accessory
    bus(1'b1, CONFIG_OFFSET, 32'h0006_0700);
    part.pins(1'b0, 1'b1, 1'b1);
    wn(8);
    chk(power_stage_en, 1'b0);
    chk(accessory_out, 1'b0);
    part.pins(1'b0, 1'b0, 1'b0);
    wn(8);
    chk(power_stage_en, 1'b1);
    chk(accessory_out, 1'b1);
    // accessory follows motor activity
    bus(1'b1, CONFIG_OFFSET, 32'h0010_0700);
    part.pins(1'b0, 1'b1, 1'b1);
    cmd(8'h00, 8'h00, 8'h00, 8'h00);
    wn(2);
    chk(accessory_out, 1'b0);
    cmd(8'h40, 8'h00, 8'h40, 8'h00);
    wn(2);
    chk(accessory_out, 1'b1);
    // emergency stop, then switch released
    bus(1'b1, CONFIG_OFFSET, 32'h0000_1700);
    part.pins(1'b1, 1'b1, 1'b1);
    wn(FH + 8);
    chk(emergency_stopped, 1'b1);
    chk(motor_cmd_ch1, 8'h00);
    part.pins(1'b0, 1'b1, 1'b1);
    wn(FH + 8);
    part.send(8'h30, 8'h30);
    wn(2);
    chk(emergency_stopped, 1'b1);
    chk(motor_cmd_ch1, 8'h00);
    // status word: stop latched, power on, outputs zero
    bus(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0000_0005);
    chk(hresp, 1'b0);
    // mid-run reset is the only way out of a stop
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    wn(2);
    chk(emergency_stopped, 1'b0);
    cmd(8'h30, 8'hD0, 8'h30, 8'hD0);
    final_report();
  end
endmodule
